/* tct_host_model.sv */
// Host CPU model issuing byte wide I/O reads and writes to the timer
`timescale 1ns/100ps
`default_nettype none
module tct_host_model (
  // Clock
  input wire logic sys_clk_in,
  // Byte I/O towards the timer
  output logic [7:0] io_addr_out,
  output logic io_wr_out,
  output logic io_rd_out,
  output logic [7:0] io_wdata_out,
  input wire logic [7:0] io_rdata_in
);
  // Idle cycles after each access, raised to act as a slow host
  int gap = 0;

  // Bus idle at start, strobes low
  initial begin
    io_addr_out = 8'h00;
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_wdata_out = 8'h00;
  end

  // byte write pulse
  // Caller orders control before count; address and data are inverted
  // once released so a stale byte can never pass for a fresh one
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    io_addr_out = addr;
    io_wdata_out = data;
    io_wr_out = 1'b1;
    @(negedge sys_clk_in);
    io_wr_out = 1'b0;
    io_addr_out = ~addr;
    io_wdata_out = ~data;
    repeat (gap) @(negedge sys_clk_in);
  endtask

  // Byte read, data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk_in);
    io_addr_out = addr;
    io_rd_out = 1'b1;
    @(negedge sys_clk_in);
    io_rd_out = 1'b0;
    io_addr_out = ~addr;
    @(negedge sys_clk_in);
    data = io_rdata_in;
    repeat (gap) @(negedge sys_clk_in);
  endtask
endmodule
`default_nettype wire

/* tct_interval_timer.sv */
// Three channel 16-bit interval timer with byte wide host port
//
// Functional notes
// - Three 16-bit counters, binary or decimal
// - One shared timer clock for all counters
// - Counter 0 output drives interrupt input zero
// - Only counter 2 gate external; first_counter_output internal
// - Load or decrement only on clock fall
// - Zero count means 65536 or 10000 steps
// - Modes 2,3 reload; others wrap around
// - Count enters through input latches, one tick
// - Reads via output latches, transparent unless frozen
// - Data ports 040h-042h, control 043h write-only
// - Control word: command, mode, decimal flag
// - Command picks counter and byte format
// - Mode field decoding with x10, x11 overlap
// - New count accepted any time after programming
// - Latch freezes count until read or reprogram
// - Repeated latch before read is ignored
// - Read-back freezes counts and captures status
// - Read-back lowest bit must be zero
// - Captured status returned on next read
// - Read-back bits 3..1 select counters 2..0
// - Status byte: out, null, format, mode, bcd
// - Null flag set by writes, cleared on load
`timescale 1ns/100ps
`default_nettype none
module tct_interval_timer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Timer pins
  input wire logic timer_clock_in,
  input wire logic third_counter_gate_in,
  // Host byte I/O
  input wire logic [7:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Counter outputs
  output logic irq_input_zero_out,
  output logic counter1_out,
  output logic third_counter_out
);

  // Decimal aware decrement; zero wraps to the top count
  function automatic logic [15:0] tct_dec(input logic [15:0] v,
                                          input logic bcd);
    logic [15:0] r;
    logic brw;
    r = v - tct_pkg::TCT_CE_ONE;
    brw = 1'b1;
    if (bcd) begin
      r = v;
      for (int k = 0; k < 4; k++) begin
        if (brw) begin
          if (r[k*4 +: 4] == 4'h0) begin
            r[k*4 +: 4] = 4'h9;
          end else begin
            r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Mode field to operating mode
  function automatic tct_pkg::tct_mode_e tct_decode(input logic [2:0] m);
    tct_pkg::tct_mode_e r;
    r = tct_pkg::TCT_M0_TERMINAL;
    unique case (m)
      3'h0: r = tct_pkg::TCT_M0_TERMINAL;
      3'h1: r = tct_pkg::TCT_M1_ONESHOT;
      3'h2, 3'h6: r = tct_pkg::TCT_M2_RATE;
      3'h3, 3'h7: r = tct_pkg::TCT_M3_SQUARE;
      3'h4: r = tct_pkg::TCT_M4_SW_STROBE;
      3'h5: r = tct_pkg::TCT_M5_HW_STROBE;
    endcase
    return r;
  endfunction

  logic tclk_s1_q, tclk_s2_q, tclk_s3_q;
  logic gate_s1_q, gate_s2_q, gate_s3_q;
  logic gate_lvl_q, trig_q;
  logic tick_fall, tick_rise;
  logic [15:0] ce_q [3];
  logic [15:0] ol_q [3];
  logic [7:0] cil_q [3];
  logic [7:0] cih_q [3];
  logic [7:0] stat_q [3];
  logic [2:0] mode_q [3];
  logic [1:0] rw_q [3];
  logic [2:0] bcd_q, out_q, nc_q, pend_q, run_q, arm_q, cnt_ok_q;
  logic [2:0] lat_q, st_q, rflip_q, wflip_q;
  logic [15:0] ld_w [3];
  logic [15:0] nxt_w [3];
  logic [2:0] gate_w, trig_w, ld_go, dec_go, out_nx, arm_nx;
  logic hit, ctl_wr, dat_wr, dat_rd;
  logic [1:0] idx, sel, fmt, rd_ch;
  logic [15:0] rd_cnt;

  // Host address decode
  // data ports then write-only control word
  assign hit = (io_addr_in[7:2] == tct_pkg::TCT_CTR0_OFS[7:2]);
  assign idx = io_addr_in[1:0];
  assign ctl_wr = io_wr_in & hit & (idx == tct_pkg::TCT_CTRL_OFS[1:0]);
  assign dat_wr = io_wr_in & hit & (idx != tct_pkg::TCT_CTRL_OFS[1:0]);
  assign dat_rd = io_rd_in & hit & (idx != tct_pkg::TCT_CTRL_OFS[1:0]);
  // command in bits 7-4, mode 3-1, decimal flag 0
  assign sel = io_wdata_in[tct_pkg::TCT_SEL_LSB +: 2];
  assign fmt = io_wdata_in[tct_pkg::TCT_FMT_LSB +: 2];

  // Timer pins cross into the system clock by two flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_s3_q <= 1'b0;
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      gate_s3_q <= 1'b0;
    end else begin
      tclk_s1_q <= timer_clock_in;
      tclk_s2_q <= tclk_s1_q;
      tclk_s3_q <= tclk_s2_q;
      gate_s1_q <= third_counter_gate_in;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
    end
  end

  // one timer clock edge strobe shared by all counters
  assign tick_fall = tclk_s3_q & ~tclk_s2_q;
  assign tick_rise = ~tclk_s3_q & tclk_s2_q;

  // Gate level sampled on clock rise; rising edge held until a tick
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_lvl_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (tick_rise) begin
        gate_lvl_q <= gate_s2_q;
      end
      // A new edge in the consuming cycle is kept
      trig_q <= (trig_q & ~tick_fall) | (gate_s2_q & ~gate_s3_q);
    end
  end

  // counters 0 and 1 have no gate pin, so they stay enabled
  assign gate_w = {gate_lvl_q, 1'b1, 1'b1};
  assign trig_w = {trig_q, 1'b0, 1'b0};

  // Per counter reload value, next count and mode decisions
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ld_w[i] = {cih_q[i], cil_q[i]};
      // zero loaded counts the full range through the wrap
      nxt_w[i] = tct_dec(ce_q[i], bcd_q[i]);
      ld_go[i] = 1'b0;
      dec_go[i] = 1'b0;
      out_nx[i] = out_q[i];
      arm_nx[i] = arm_q[i];
      unique case (tct_decode(mode_q[i]))
        tct_pkg::TCT_M0_TERMINAL: begin
          ld_go[i] = pend_q[i];
          dec_go[i] = run_q[i] & ~pend_q[i] & gate_w[i];
          if (dec_go[i] && ce_q[i] == tct_pkg::TCT_CE_ONE) begin
            out_nx[i] = 1'b1;
          end
        end
        tct_pkg::TCT_M1_ONESHOT: begin
          ld_go[i] = trig_w[i] & cnt_ok_q[i];
          dec_go[i] = ~ld_go[i];
          if (ld_go[i]) begin
            out_nx[i] = 1'b0;
            arm_nx[i] = 1'b1;
          end else if (arm_q[i] && ce_q[i] == tct_pkg::TCT_CE_ONE) begin
            out_nx[i] = 1'b1;
            arm_nx[i] = 1'b0;
          end
        end
        tct_pkg::TCT_M2_RATE, tct_pkg::TCT_M3_SQUARE: begin
          // these modes reload at the end of each period
          ld_go[i] = (pend_q[i] & ~run_q[i]) | trig_w[i] |
                     (gate_w[i] & run_q[i] &
                      (ce_q[i] == tct_pkg::TCT_CE_ONE));
          dec_go[i] = ~ld_go[i] & gate_w[i] & run_q[i];
          if (mode_q[i][0]) begin
            out_nx[i] = ld_go[i] | ~gate_w[i] |
                        (nxt_w[i] > {1'b0, ld_w[i][15:1]});
          end else begin
            out_nx[i] = ~(dec_go[i] & (ce_q[i] == tct_pkg::TCT_CE_TWO));
          end
        end
        tct_pkg::TCT_M4_SW_STROBE, tct_pkg::TCT_M5_HW_STROBE: begin
          if (mode_q[i][0]) begin
            ld_go[i] = trig_w[i] & cnt_ok_q[i];
            dec_go[i] = ~ld_go[i];
          end else begin
            ld_go[i] = pend_q[i];
            dec_go[i] = run_q[i] & ~pend_q[i] & gate_w[i];
          end
          out_nx[i] = ~(dec_go[i] & arm_q[i] &
                        (ce_q[i] == tct_pkg::TCT_CE_ONE));
          arm_nx[i] = ld_go[i] | (arm_q[i] & out_nx[i]);
        end
      endcase
    end
  end

  // Counting element, latches and per counter flags
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 3; i++) begin
        ce_q[i] <= tct_pkg::TCT_CE_RST;
        ol_q[i] <= tct_pkg::TCT_CE_RST;
        cil_q[i] <= tct_pkg::TCT_BYTE_RST;
        cih_q[i] <= tct_pkg::TCT_BYTE_RST;
        stat_q[i] <= tct_pkg::TCT_BYTE_RST;
        mode_q[i] <= tct_pkg::TCT_MODE_RST;
        rw_q[i] <= tct_pkg::TCT_FMT_RST;
      end
      bcd_q <= tct_pkg::TCT_FLAG_RST;
      out_q <= tct_pkg::TCT_FLAG_RST;
      nc_q <= tct_pkg::TCT_FLAG_RST;
      pend_q <= tct_pkg::TCT_FLAG_RST;
      run_q <= tct_pkg::TCT_FLAG_RST;
      arm_q <= tct_pkg::TCT_FLAG_RST;
      cnt_ok_q <= tct_pkg::TCT_FLAG_RST;
      lat_q <= tct_pkg::TCT_FLAG_RST;
      st_q <= tct_pkg::TCT_FLAG_RST;
      rflip_q <= tct_pkg::TCT_FLAG_RST;
      wflip_q <= tct_pkg::TCT_FLAG_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // element moves only on the timer clock fall
        if (tick_fall) begin
          out_q[i] <= out_nx[i];
          arm_q[i] <= arm_nx[i];
          if (ld_go[i]) begin
            // input latches transfer in one tick
            ce_q[i] <= ld_w[i];
            pend_q[i] <= 1'b0;
            run_q[i] <= 1'b1;
            nc_q[i] <= 1'b0;
          end else if (dec_go[i]) begin
            ce_q[i] <= nxt_w[i];
          end
        end
        if (ctl_wr && sel == 2'(i)) begin
          if (fmt == tct_pkg::TCT_FMT_LATCH) begin
            // only the first latch before a read counts
            if (!lat_q[i]) begin
              ol_q[i] <= ce_q[i];
              lat_q[i] <= 1'b1;
            end
          end else begin
            mode_q[i] <= io_wdata_in[tct_pkg::TCT_MODE_LSB +: 3];
            rw_q[i] <= fmt;
            bcd_q[i] <= io_wdata_in[tct_pkg::TCT_BCD_BIT];
            out_q[i] <= (io_wdata_in[3:1] != 3'h0);
            nc_q[i] <= 1'b1;
            lat_q[i] <= 1'b0;
            st_q[i] <= 1'b0;
            rflip_q[i] <= 1'b0;
            wflip_q[i] <= 1'b0;
            pend_q[i] <= 1'b0;
            run_q[i] <= 1'b0;
            arm_q[i] <= 1'b0;
            cnt_ok_q[i] <= 1'b0;
          end
        end
        // read-back bits 1..3 pick counters 0..2
        // lowest bit of a read-back is not looked at
        if (ctl_wr && sel == tct_pkg::TCT_SEL_RB && io_wdata_in[1 + i]) begin
          if (!fmt[1] && !lat_q[i]) begin
            ol_q[i] <= ce_q[i];
            lat_q[i] <= 1'b1;
          end
          if (!fmt[0] && !st_q[i]) begin
            stat_q[i] <= {out_q[i], nc_q[i], rw_q[i], mode_q[i], bcd_q[i]};
            st_q[i] <= 1'b1;
          end
        end
        // a count may follow at any time in the set format
        if (dat_wr && idx == 2'(i)) begin
          nc_q[i] <= 1'b1;
          if (tct_decode(mode_q[i]) == tct_pkg::TCT_M0_TERMINAL) begin
            out_q[i] <= 1'b0;
          end
          if (rw_q[i] == tct_pkg::TCT_FMT_LOW) begin
            cil_q[i] <= io_wdata_in;
            cih_q[i] <= tct_pkg::TCT_BYTE_RST;
          end else if (rw_q[i] == tct_pkg::TCT_FMT_HIGH) begin
            cih_q[i] <= io_wdata_in;
            cil_q[i] <= tct_pkg::TCT_BYTE_RST;
          end else if (!wflip_q[i]) begin
            cil_q[i] <= io_wdata_in;
          end else begin
            cih_q[i] <= io_wdata_in;
          end
          if (rw_q[i] == tct_pkg::TCT_FMT_BOTH) begin
            wflip_q[i] <= ~wflip_q[i];
          end
          // Pending wins over a load in the same cycle
          if (rw_q[i] != tct_pkg::TCT_FMT_BOTH || wflip_q[i]) begin
            pend_q[i] <= 1'b1;
            cnt_ok_q[i] <= 1'b1;
          end
        end
        // status goes out first, then the count bytes
        if (dat_rd && idx == 2'(i)) begin
          if (st_q[i]) begin
            st_q[i] <= 1'b0;
          end else if (rw_q[i] == tct_pkg::TCT_FMT_BOTH && !rflip_q[i]) begin
            rflip_q[i] <= 1'b1;
          end else begin
            rflip_q[i] <= 1'b0;
            lat_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // frozen copy while latched, live element otherwise
  assign rd_ch = (idx == tct_pkg::TCT_CTRL_OFS[1:0]) ? 2'h0 : idx;
  assign rd_cnt = lat_q[rd_ch] ? ol_q[rd_ch] : ce_q[rd_ch];

  // Read data register; control word port reads as zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io_rdata_out <= tct_pkg::TCT_RDATA_IDLE;
    end else if (io_rd_in && hit) begin
      if (!dat_rd) begin
        io_rdata_out <= tct_pkg::TCT_RDATA_IDLE;
      end else if (st_q[rd_ch]) begin
        io_rdata_out <= stat_q[rd_ch];
      end else if (rw_q[rd_ch] == tct_pkg::TCT_FMT_HIGH ||
                   (rw_q[rd_ch] == tct_pkg::TCT_FMT_BOTH && rflip_q[rd_ch]))
      begin
        io_rdata_out <= rd_cnt[15:8];
      end else begin
        io_rdata_out <= rd_cnt[7:0];
      end
    end
  end

  // counter 0 output goes to interrupt input zero only
  assign irq_input_zero_out = out_q[0];
  assign counter1_out = out_q[1];
  assign third_counter_out = out_q[2];

  default clocking tct_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_prog_sets_nc: assert property (
    ctl_wr && sel == 2'h0 && fmt != tct_pkg::TCT_FMT_LATCH |=>
      nc_q[0] && !lat_q[0] && rw_q[0] == $past(fmt))
    else $error("programming did not set null flag");
  a_load_clears_nc: assert property (
    tick_fall && ld_go[0] && !(dat_wr && idx == 2'h0) &&
    !(ctl_wr && sel == 2'h0) |=>
      ce_q[0] == $past(ld_w[0]) && !nc_q[0])
    else $error("load from input latches wrong");
  a_hold_off_tick: assert property (
    !tick_fall |=> $stable(ce_q[0]))
    else $error("element moved without a timer clock fall");
  a_wrap_bin: assert property (
    tick_fall && dec_go[0] && ce_q[0] == 16'h0000 && !bcd_q[0] |=>
      ce_q[0] == 16'hffff)
    else $error("binary wrap wrong");
  a_wrap_bcd: assert property (
    tick_fall && dec_go[0] && ce_q[0] == 16'h0000 && bcd_q[0] |=>
      ce_q[0] == 16'h9999)
    else $error("decimal wrap wrong");
  a_rate_reload: assert property (
    tick_fall && mode_q[0][1:0] == 2'h2 && run_q[0] &&
    ce_q[0] == 16'h0001 |=> ce_q[0] == $past(ld_w[0]))
    else $error("rate mode did not reload");
  a_latch_take: assert property (
    ctl_wr && io_wdata_in[7:4] == 4'h0 && !lat_q[0] |=>
      lat_q[0] && ol_q[0] == $past(ce_q[0]))
    else $error("latch command did not freeze count");
  a_latch_hold: assert property (
    lat_q[0] && $past(lat_q[0]) |-> ol_q[0] == $past(ol_q[0]))
    else $error("frozen count changed");
  a_status_read: assert property (
    dat_rd && idx == 2'h0 && st_q[0] |=>
      io_rdata_out == $past(stat_q[0]) && !st_q[0])
    else $error("status byte not returned first");
  a_rb_status: assert property (
    ctl_wr && sel == 2'h3 && !fmt[0] && io_wdata_in[1] && !st_q[0] |=>
      st_q[0] && stat_q[0][7] == $past(out_q[0]) &&
      stat_q[0][5:1] == $past({rw_q[0], mode_q[0]}))
    else $error("read-back status capture wrong");
  a_ctrl_reads_zero: assert property (
    io_rd_in && hit && idx == 2'h3 |=> io_rdata_out == 8'h00)
    else $error("control port read not zero");

  c_rate_reload: cover property (
    tick_fall && mode_q[0][1:0] == 2'h2 && ld_go[0] && run_q[0]);
  c_latch_read: cover property (lat_q[0] ##[1:20] dat_rd && idx == 2'h0);
  c_status_read: cover property (st_q[2] && dat_rd && idx == 2'h2);
  c_bcd_wrap: cover property (
    tick_fall && dec_go[1] && bcd_q[1] && ce_q[1] == 16'h0000);

endmodule
`default_nettype wire

/* tct_interval_timer_tb.sv */
// Self-checking testbench for the three channel interval timer
`timescale 1ns/100ps
`default_nettype none
module tct_interval_timer_tb;
  logic sys_clk;
  logic arst_n;
  logic tmr_clk;
  logic gate;
  logic [7:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic first_counter_output;
  logic out1;
  logic out2;
  int error_cnt = 0;
  int total_checks = 0;

  // Design under test
  tct_interval_timer i_tct_interval_timer (
    .sys_clk_in(sys_clk),
    .arst_n_in(arst_n),
    .timer_clock_in(tmr_clk),
    .third_counter_gate_in(gate),
    .io_addr_in(io_addr),
    .io_wr_in(io_wr),
    .io_rd_in(io_rd),
    .io_wdata_in(io_wdata),
    .io_rdata_out(io_rdata),
    .irq_input_zero_out(first_counter_output),
    .counter1_out(out1),
    .third_counter_out(out2)
  );

  // Host side partner
  tct_host_model i_tct_host_model (
    .sys_clk_in(sys_clk),
    .io_addr_out(io_addr),
    .io_wr_out(io_wr),
    .io_rd_out(io_rd),
    .io_wdata_out(io_wdata),
    .io_rdata_in(io_rdata)
  );

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Byte comparison
  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Pin level comparison
  task automatic chk_pin(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Read one byte and compare
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_tct_host_model.rd(addr, d);
    chk_byte(exp, d);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_tct_host_model.wr(addr, data);
  endtask

  // Timer pulses; both phases well over the three cycle sync delay
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      tmr_clk = 1'b1;
      repeat (4) @(negedge sys_clk);
      tmr_clk = 1'b0;
      repeat (6) @(negedge sys_clk);
    end
  endtask

  // Counter 0: load, count, reload without control word, wrap
  task automatic t_load_read();
    wr(tct_pkg::TCT_CTRL_OFS, 8'h30);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h34);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h12);
    tick(1);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h34);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h12);
    tick(3);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h31);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h12);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h05);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h00);
    tick(1);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h05);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h00);
    tick(4);
    chk_pin(1'b0, first_counter_output);
    tick(1);
    chk_pin(1'b1, first_counter_output);
    tick(1);
    // Freeze the wrapped count, then let the element move on
    wr(tct_pkg::TCT_CTRL_OFS, 8'h00);
    tick(1);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hff);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hff);
    // Status of counter 0 comes first, then the live count
    wr(tct_pkg::TCT_CTRL_OFS, 8'he2);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hb0);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hfe);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hff);
    // Unmapped read must leave the last data byte alone
    rd_chk(8'h50, 8'hff);
    rd_chk(tct_pkg::TCT_CTRL_OFS, 8'h00);
  endtask

  // Zero count in decimal and binary, low byte only
  task automatic t_zero();
    wr(tct_pkg::TCT_CTRL_OFS, 8'h11);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h00);
    tick(2);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h99);
    wr(tct_pkg::TCT_CTRL_OFS, 8'h10);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h00);
    tick(2);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'hff);
    // Rate mode: load, two steps, then reload from the input latches
    wr(tct_pkg::TCT_CTRL_OFS, 8'h14);
    wr(tct_pkg::TCT_CTR0_OFS, 8'h03);
    tick(4);
    rd_chk(tct_pkg::TCT_CTR0_OFS, 8'h03);
    chk_pin(1'b1, first_counter_output);
  endtask

  // Counter 1 latch held across ticks, second latch ignored
  task automatic t_latch();
    i_tct_host_model.gap = 2;
    wr(tct_pkg::TCT_CTRL_OFS, 8'h70);
    wr(tct_pkg::TCT_CTR1_OFS, 8'h00);
    wr(tct_pkg::TCT_CTR1_OFS, 8'h01);
    tick(1);
    wr(tct_pkg::TCT_CTRL_OFS, 8'h40);
    tick(2);
    wr(tct_pkg::TCT_CTRL_OFS, 8'h40);
    rd_chk(tct_pkg::TCT_CTR1_OFS, 8'h00);
    rd_chk(tct_pkg::TCT_CTR1_OFS, 8'h01);
    rd_chk(tct_pkg::TCT_CTR1_OFS, 8'hfe);
    rd_chk(tct_pkg::TCT_CTR1_OFS, 8'h00);
    i_tct_host_model.gap = 0;
  endtask

  // Counter 2 read-back of status and count
  task automatic t_readback();
    wr(tct_pkg::TCT_CTRL_OFS, 8'hb4);
    wr(tct_pkg::TCT_CTRL_OFS, 8'he8);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'hf4);
    wr(tct_pkg::TCT_CTR2_OFS, 8'h10);
    wr(tct_pkg::TCT_CTR2_OFS, 8'h00);
    tick(1);
    // Bit 0 set on purpose; the device must ignore it
    wr(tct_pkg::TCT_CTRL_OFS, 8'hc9);
    tick(1);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'hb4);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h10);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h00);
    chk_pin(1'b1, out2);
    // Gate low holds the count; its rising edge reloads it
    gate = 1'b0;
    tick(2);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h0f);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h00);
    chk_pin(1'b1, out2);
    gate = 1'b1;
    tick(1);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h10);
    rd_chk(tct_pkg::TCT_CTR2_OFS, 8'h00);
  endtask

  // Every mode code on counter 1, seen through status and pin
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(tct_pkg::TCT_CTRL_OFS, {4'h5, m, 1'b0});
      wr(tct_pkg::TCT_CTRL_OFS, 8'he4);
      rd_chk(tct_pkg::TCT_CTR1_OFS, {m != 3'h0, 3'h5, m, 1'b0});
      chk_pin(m != 3'h0, out1);
    end
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    tmr_clk = 1'b0;
    gate = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_load_read();
    t_zero();
    t_latch();
    t_readback();
    t_modes();
    conclude();
  end
endmodule
`default_nettype wire

/* tct_pkg.sv */
// Constants, encodings and mode type for the interval timer
package tct_pkg;
  // Byte I/O addresses of the data ports and the control word
  localparam logic [7:0] TCT_CTR0_OFS = 8'h40;
  localparam logic [7:0] TCT_CTR1_OFS = 8'h41;
  localparam logic [7:0] TCT_CTR2_OFS = 8'h42;
  localparam logic [7:0] TCT_CTRL_OFS = 8'h43;
  // Field positions in the control word
  localparam int TCT_SEL_LSB = 6;
  localparam int TCT_FMT_LSB = 4;
  localparam int TCT_MODE_LSB = 1;
  localparam int TCT_BCD_BIT = 0;
  localparam int TCT_NUM_CTR = 3;
  // Counter select and byte format codes
  localparam logic [1:0] TCT_SEL_RB = 2'h3;
  localparam logic [1:0] TCT_FMT_LATCH = 2'h0;
  localparam logic [1:0] TCT_FMT_LOW = 2'h1;
  localparam logic [1:0] TCT_FMT_HIGH = 2'h2;
  localparam logic [1:0] TCT_FMT_BOTH = 2'h3;
  // Values after reset
  localparam logic [15:0] TCT_CE_RST = 16'h0000;
  localparam logic [7:0] TCT_BYTE_RST = 8'h00;
  localparam logic [2:0] TCT_MODE_RST = 3'h0;
  localparam logic [1:0] TCT_FMT_RST = 2'h1;
  localparam logic [2:0] TCT_FLAG_RST = 3'h0;
  localparam logic [7:0] TCT_RDATA_IDLE = 8'h00;
  // Counting element values that steer the modes
  localparam logic [15:0] TCT_CE_ONE = 16'h0001;
  localparam logic [15:0] TCT_CE_TWO = 16'h0002;
  // Counter operating modes
  typedef enum logic [2:0] {
    TCT_M0_TERMINAL,
    TCT_M1_ONESHOT,
    TCT_M2_RATE,
    TCT_M3_SQUARE,
    TCT_M4_SW_STROBE,
    TCT_M5_HW_STROBE
  } tct_mode_e;
endpackage
